// File: hdl/ifca_pkg.sv
// Purpose: Shared constants and types for the two-wire memory/companion link.
// Assumes: 125 MHz system clock on both ends.
// Notes:   Memory and companion identities share one header layout.

package ifca_pkg;

   // ------------------------------------------------------------------
   // Identities and address map
   // ------------------------------------------------------------------
   localparam logic [3:0] IFCA_MEM_ID = 4'hA;
   localparam logic [3:0] IFCA_REG_ID = 4'hD;
   localparam int IFCA_MEM_AW = 15;
   localparam logic [14:0] IFCA_MEM_TOP = 15'h7FFF;
   localparam logic [14:0] IFCA_MEM_RST = 15'h0000;
   localparam int IFCA_REG_AW = 5;
   localparam logic [7:0] IFCA_REG_MAX = 8'h18;
   localparam logic [4:0] IFCA_REG_RST = 5'h00;
   localparam int IFCA_REG_CNT = 25;

   // ------------------------------------------------------------------
   // Bit slots within one byte frame
   // ------------------------------------------------------------------
   localparam logic [3:0] IFCA_BIT_LAST = 4'h7;
   localparam logic [3:0] IFCA_BIT_ACK = 4'h8;
   localparam logic [3:0] IFCA_BIT_END = 4'h9;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int IFCA_CLK_NS = 8;
   localparam int IFCA_SCL_PERIOD_NS = 10000;
   localparam int IFCA_QTR_CYC =
      (IFCA_SCL_PERIOD_NS / 4 + IFCA_CLK_NS - 1) / IFCA_CLK_NS;

   typedef enum logic [1:0] {
      IFCA_CMD_START,
      IFCA_CMD_STOP,
      IFCA_CMD_WRITE,
      IFCA_CMD_READ
   } ifca_cmd_e;

endpackage : ifca_pkg

// File: hdl/ifca_bus_if.sv
// Purpose: Open-drain two-wire bus joining the master and the device.
// Assumes: Passive pull-up on both lines.
// Notes:   A line is low when any end enables its low driver.

`timescale 1ns/1ps
`default_nettype none

interface ifca_bus_if;
   logic h_scl_o;
   logic h_scl_oe_n;
   logic h_sda_o;
   logic h_sda_oe_n;
   logic d_sda_o;
   logic d_sda_oe_n;
   logic scl;
   logic sda;

   assign scl = ~(~h_scl_oe_n & ~h_scl_o);
   assign sda = ~((~h_sda_oe_n & ~h_sda_o) | (~d_sda_oe_n & ~d_sda_o));

   modport dev (input scl, input sda, output d_sda_o, output d_sda_oe_n);
   modport host (input scl, input sda, output h_scl_o, output h_scl_oe_n,
                 output h_sda_o, output h_sda_oe_n);
endinterface : ifca_bus_if

`default_nettype wire

// File: hdl/ifca_dev.sv
// Purpose: Bus slave for a byte memory and a companion register file.
// Assumes: Bus lines and select pins are asynchronous to clk_sys.
// Notes:   Bus must run well below clk_sys/8 for the edge detection.

`timescale 1ns/1ps
`default_nettype none

// Function
// - Master opens writes with memory header, address, data.
// - Unlimited write bytes acknowledged; address wraps to zero.
// - No write busy time; always ready.
// - Byte committed at eighth bit, before acknowledge.
// - START or STOP before eighth bit aborts write.
// - Each byte written directly, no page buffer.
// - Read header starts data from current address.
// - Reads increment address; acknowledge fetches next byte.
// - Master ends reads by NACK or condition.
// - Reads past top location continue from zero.
// - Selective read: write header, address, restart, read.
// - Register writes use companion identity, one address.
// - Master should keep register address top bits zero.
// - Register reads start at current register address.
// - Memory and register address latches stay separate.
// - Master always gives an address for writes.
// - First address byte high, second low; top ignored.
// - Memory spans fifteen address bits.
// - Two identities: memory and companion registers.
// - Header select bits must match select pins.
// - Register address above 18h is refused, aborted.
// - Bytes travel MSB first; NACK ends read.
module ifca_dev #(
   parameter int MEM_DEPTH = 32768
) (
   input wire logic clk_sys,
   input wire logic nrst,
   ifca_bus_if.dev bus,
   input wire logic [1:0] sel_pins,
   output var logic [ifca_pkg::IFCA_MEM_AW-1:0] mem_addr,
   output var logic [ifca_pkg::IFCA_REG_AW-1:0] reg_addr
);
   import ifca_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_HDR, ST_AHI, ST_ALO, ST_WR, ST_RD
   } ifca_st_e;

   // ------------------------------------------------------------------
   // Input synchronisers and condition detection
   // ------------------------------------------------------------------
   logic scl_m, scl_s, scl_p;
   logic sda_m, sda_s, sda_p;
   logic [1:0] sel_m, sel_s;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_p <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_p <= 1'b1;
         sel_m <= 2'h0;
         sel_s <= 2'h0;
      end else begin
         scl_m <= bus.scl;
         scl_s <= scl_m;
         scl_p <= scl_s;
         sda_m <= bus.sda;
         sda_s <= sda_m;
         sda_p <= sda_s;
         sel_m <= sel_pins;
         sel_s <= sel_m;
      end
   end

   logic rise, fall, start_c, stop_c;
   assign rise = scl_s & ~scl_p;
   assign fall = ~scl_s & scl_p;
   assign start_c = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_c = scl_s & scl_p & ~sda_p & sda_s;

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   logic [7:0] mem [MEM_DEPTH];
   logic [7:0] regs [IFCA_REG_CNT];

   ifca_st_e st_q, nxt_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic [6:0] hi_q;
   logic ack_q, mack_q, tgt_reg_q, drive_q;
   logic [14:0] maddr_q;
   logic [4:0] raddr_q;

   logic rcv, byte_in;
   logic [7:0] nb, rd_byte;
   assign rcv = (st_q == ST_HDR) | (st_q == ST_AHI) | (st_q == ST_ALO) |
                (st_q == ST_WR);
   assign nb = {sh_q[6:0], sda_s};
   assign byte_in = rise & (cnt_q == IFCA_BIT_LAST) & rcv;
   assign rd_byte = tgt_reg_q ? regs[raddr_q] : mem[maddr_q];

   function automatic logic [14:0] mem_inc(input logic [14:0] a);
      mem_inc = (a == IFCA_MEM_TOP) ? IFCA_MEM_RST : a + 15'h0001;
   endfunction : mem_inc

   function automatic logic [4:0] reg_inc(input logic [4:0] a);
      reg_inc = (a == IFCA_REG_MAX[4:0]) ? IFCA_REG_RST : a + 5'h01;
   endfunction : reg_inc

   // ------------------------------------------------------------------
   // Array writes
   // ------------------------------------------------------------------
   // Writing at the eighth rising edge keeps the commit ahead of the
   // acknowledge, and a condition earlier never reaches this point.
   always_ff @(posedge clk_sys) begin
      if (byte_in && st_q == ST_WR && !tgt_reg_q) begin
         mem[maddr_q] <= nb;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (byte_in && st_q == ST_WR && tgt_reg_q) begin
         regs[raddr_q] <= nb;
      end
   end

   // ------------------------------------------------------------------
   // Bus state machine and address latches
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         hi_q <= 7'h00;
         ack_q <= 1'b0;
         mack_q <= 1'b0;
         tgt_reg_q <= 1'b0;
         drive_q <= 1'b0;
         maddr_q <= IFCA_MEM_RST;
         raddr_q <= IFCA_REG_RST;
      end else if (start_c) begin
         st_q <= ST_HDR;
         cnt_q <= 4'h0;
         drive_q <= 1'b0;
      end else if (stop_c) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         drive_q <= 1'b0;
      end else if (st_q != ST_IDLE) begin
         if (rise) begin
            if (cnt_q < IFCA_BIT_ACK) begin
               cnt_q <= cnt_q + 4'h1;
            end
            if (rcv) begin
               sh_q <= nb;
            end
            if (cnt_q == IFCA_BIT_END && st_q == ST_RD) begin
               mack_q <= ~sda_s;
            end
            if (byte_in) begin
               case (st_q)
                  ST_HDR: begin
                     if ((nb[7:4] == IFCA_MEM_ID || nb[7:4] == IFCA_REG_ID) &&
                         nb[2:1] == sel_s) begin
                        ack_q <= 1'b1;
                        tgt_reg_q <= (nb[7:4] == IFCA_REG_ID);
                        nxt_q <= nb[0] ? ST_RD : ST_AHI;
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
                  ST_AHI: begin
                     if (!tgt_reg_q) begin
                        hi_q <= nb[6:0];
                        ack_q <= 1'b1;
                        nxt_q <= ST_ALO;
                     end else if (nb > IFCA_REG_MAX) begin
                        st_q <= ST_IDLE;
                     end else begin
                        raddr_q <= nb[4:0];
                        ack_q <= 1'b1;
                        nxt_q <= ST_WR;
                     end
                  end
                  ST_ALO: begin
                     maddr_q <= {hi_q, nb};
                     ack_q <= 1'b1;
                     nxt_q <= ST_WR;
                  end
                  ST_WR: begin
                     ack_q <= 1'b1;
                     nxt_q <= ST_WR;
                     if (tgt_reg_q) begin
                        raddr_q <= reg_inc(raddr_q);
                     end else begin
                        maddr_q <= mem_inc(maddr_q);
                     end
                  end
                  default: begin
                     st_q <= ST_IDLE;
                  end
               endcase
            end
         end else if (fall) begin
            if (cnt_q == IFCA_BIT_ACK) begin
               cnt_q <= IFCA_BIT_END;
               drive_q <= (st_q == ST_RD) ? 1'b0 : ack_q;
            end else if (cnt_q == IFCA_BIT_END) begin
               cnt_q <= 4'h0;
               ack_q <= 1'b0;
               if (st_q == ST_RD && !mack_q) begin
                  st_q <= ST_IDLE;
                  drive_q <= 1'b0;
               end else if (nxt_q == ST_RD) begin
                  st_q <= ST_RD;
                  drive_q <= ~rd_byte[7];
                  sh_q <= {rd_byte[6:0], 1'b0};
                  if (tgt_reg_q) begin
                     raddr_q <= reg_inc(raddr_q);
                  end else begin
                     maddr_q <= mem_inc(maddr_q);
                  end
               end else begin
                  st_q <= nxt_q;
                  drive_q <= 1'b0;
               end
            end else if (st_q == ST_RD && cnt_q != 4'h0) begin
               drive_q <= ~sh_q[7];
               sh_q <= {sh_q[6:0], 1'b0};
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bus.d_sda_o <= 1'b0;
         bus.d_sda_oe_n <= 1'b1;
         mem_addr <= IFCA_MEM_RST;
         reg_addr <= IFCA_REG_RST;
      end else begin
         bus.d_sda_o <= 1'b0;
         bus.d_sda_oe_n <= ~drive_q;
         mem_addr <= maddr_q;
         reg_addr <= raddr_q;
      end
   end

endmodule : ifca_dev

`default_nettype wire

// File: hdl/ifca_host.sv
// Purpose: Two-wire bus master driven by byte-level commands.
// Assumes: No clock stretching by the slave.
// Notes:   The user sequences headers, addresses and read endings.

`timescale 1ns/1ps
`default_nettype none

module ifca_host #(
   parameter int QTR_CYC = ifca_pkg::IFCA_QTR_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   ifca_bus_if.host bus,
   input wire logic cmd_valid,
   input wire ifca_pkg::ifca_cmd_e cmd,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_nack,
   output var logic cmd_ready,
   output var logic rsp_valid,
   output var logic [7:0] rsp_data,
   output var logic rsp_ack
);
   import ifca_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} ifca_hst_e;

   // ------------------------------------------------------------------
   // Data line synchroniser and quarter-bit divider
   // ------------------------------------------------------------------
   logic sda_m, sda_s;
   logic [15:0] div_q;
   logic tick;
   ifca_hst_e st_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [8:0] tx_q, rx_q;
   logic scl_lo_q, sda_lo_q;

   assign tick = (div_q == 16'(QTR_CYC - 1));

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         sda_m <= bus.sda;
         sda_s <= sda_m;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         div_q <= 16'h0000;
      end else if (st_q == H_IDLE || tick) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end

   // ------------------------------------------------------------------
   // Bit sequencer
   // ------------------------------------------------------------------
   // Each START, STOP and bit spends four quarter-bit ticks; the clock is left low
   // after START and bits so the next operation always begins cleanly.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_q <= H_IDLE;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         tx_q <= 9'h1FF;
         rx_q <= 9'h000;
         scl_lo_q <= 1'b0;
         sda_lo_q <= 1'b0;
         cmd_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_ack <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (st_q)
            H_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  ph_q <= 2'h0;
                  bit_q <= 4'h0;
                  case (cmd)
                     IFCA_CMD_START: st_q <= H_START;
                     IFCA_CMD_STOP: st_q <= H_STOP;
                     IFCA_CMD_WRITE: begin
                        st_q <= H_BIT;
                        tx_q <= {cmd_wdata, 1'b1};
                     end
                     default: begin
                        st_q <= H_BIT;
                        tx_q <= {8'hFF, cmd_nack};
                     end
                  endcase
               end
            end
            H_START: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  case (ph_q)
                     2'h0: sda_lo_q <= 1'b0;
                     2'h1: scl_lo_q <= 1'b0;
                     2'h2: sda_lo_q <= 1'b1;
                     default: begin
                        scl_lo_q <= 1'b1;
                        st_q <= H_IDLE;
                        cmd_ready <= 1'b1;
                        rsp_valid <= 1'b1;
                     end
                  endcase
               end
            end
            H_STOP: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  case (ph_q)
                     2'h0: sda_lo_q <= 1'b1;
                     2'h1: scl_lo_q <= 1'b0;
                     2'h2: sda_lo_q <= 1'b0;
                     default: begin
                        st_q <= H_IDLE;
                        cmd_ready <= 1'b1;
                        rsp_valid <= 1'b1;
                     end
                  endcase
               end
            end
            H_BIT: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  case (ph_q)
                     2'h0: sda_lo_q <= ~tx_q[8];
                     2'h1: scl_lo_q <= 1'b0;
                     2'h2: rx_q <= {rx_q[7:0], sda_s};
                     default: begin
                        scl_lo_q <= 1'b1;
                        tx_q <= {tx_q[7:0], 1'b1};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == IFCA_BIT_ACK) begin
                           st_q <= H_IDLE;
                           cmd_ready <= 1'b1;
                           rsp_valid <= 1'b1;
                           rsp_data <= rx_q[8:1];
                           rsp_ack <= ~rx_q[0];
                        end
                     end
                  endcase
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bus.h_scl_o <= 1'b0;
         bus.h_scl_oe_n <= 1'b1;
         bus.h_sda_o <= 1'b0;
         bus.h_sda_oe_n <= 1'b1;
      end else begin
         bus.h_scl_o <= 1'b0;
         bus.h_scl_oe_n <= ~scl_lo_q;
         bus.h_sda_o <= 1'b0;
         bus.h_sda_oe_n <= ~sda_lo_q;
      end
   end

endmodule : ifca_host

`default_nettype wire

// File: sim/ifca_link_properties.sv
// Purpose: Wire-level checks on the two-wire link between both ends.
// Assumes: The watched device has its select straps at SEL.
// Notes:   Bit and byte slots are rebuilt from the resolved lines only.

`timescale 1ns/1ps
`default_nettype none

module ifca_link_properties #(
   parameter logic [1:0] SEL = 2'h0
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic h_scl_o,
   input wire logic h_scl_oe_n,
   input wire logic h_sda_o,
   input wire logic h_sda_oe_n,
   input wire logic d_sda_o,
   input wire logic d_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   import ifca_pkg::*;

   // ------------------------------------------------------------------
   // Frame tracking
   // ------------------------------------------------------------------
   logic scl_q;
   logic sda_q;
   logic [3:0] bit_q;
   logic [7:0] idx_q;
   logic [7:0] sh_q;
   logic [7:0] hdr_q;
   logic rise;
   logic start;
   logic stop;
   logic id_ok;
   logic mem_wr;
   logic reg_wr;
   logic rd_ok;

   assign rise = scl & ~scl_q;
   assign start = scl & scl_q & sda_q & ~sda;
   assign stop = scl & scl_q & ~sda_q & sda;
   assign id_ok = (sh_q[7:4] == IFCA_MEM_ID || sh_q[7:4] == IFCA_REG_ID)
                  && sh_q[2:1] == SEL;
   assign mem_wr = hdr_q == {IFCA_MEM_ID, 1'b0, SEL, 1'b0};
   assign reg_wr = hdr_q == {IFCA_REG_ID, 1'b0, SEL, 1'b0};
   assign rd_ok = hdr_q[0] && hdr_q[2:1] == SEL
                  && (hdr_q[7:4] == IFCA_MEM_ID || hdr_q[7:4] == IFCA_REG_ID);

   // Idle level of both lines is high, so no false START after reset.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bit_q <= 4'h0;
         idx_q <= 8'h00;
      end else if (start) begin
         bit_q <= 4'h0;
         idx_q <= 8'h00;
      end else if (rise && bit_q == 4'h9) begin
         bit_q <= 4'h1;
         idx_q <= (idx_q == 8'hFF) ? idx_q : idx_q + 8'h01;
      end else if (rise) begin
         bit_q <= bit_q + 4'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sh_q <= 8'h00;
      end else if (rise && bit_q != 4'h8) begin
         sh_q <= {sh_q[6:0], sda};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hdr_q <= 8'h00;
      end else if (rise && bit_q == 4'h8 && idx_q == 8'h00) begin
         hdr_q <= sh_q;
      end
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence ack_slot_s;
      rise && bit_q == 4'h8;
   endsequence

   sequence hdr_slot_s;
      ack_slot_s ##0 idx_q == 8'h00;
   endsequence

   hdr_ack_a: assert property (hdr_slot_s ##0 id_ok |-> !sda)
      else $error("header for this device not acknowledged");
   bad_hdr_a: assert property (hdr_slot_s ##0 !id_ok |-> sda)
      else $error("foreign header acknowledged");
   mem_wr_ack_a: assert property (ack_slot_s ##0 idx_q != 8'h00 && mem_wr
      |-> !sda)
      else $error("memory write byte not acknowledged");
   reg_range_a: assert property (ack_slot_s ##0 idx_q == 8'h01 && reg_wr
      |-> sda == (sh_q > IFCA_REG_MAX))
      else $error("register address acknowledge wrong");
   reg_wr_ack_a: assert property (ack_slot_s ##0 idx_q > 8'h01 && reg_wr
      |-> !sda)
      else $error("register write byte not acknowledged");
   hdr_listen_a: assert property (idx_q == 8'h00 && bit_q < 4'h8
      |-> d_sda_oe_n)
      else $error("device drove the line during a header");
   rd_slot_a: assert property (rise && bit_q < 4'h8 && idx_q != 8'h00
      && rd_ok |-> h_sda_oe_n)
      else $error("master drove a read data slot");
   dev_steady_a: assert property ($changed(d_sda_oe_n) |-> !scl)
      else $error("device changed data while clock high");
   stop_quiet_a: assert property (stop |=> d_sda_oe_n [*8])
      else $error("device drove the line after a stop");
   line_lvl_a: assert property (!h_scl_o && !h_sda_o && !d_sda_o)
      else $error("open-drain line driven high");
   one_pin_a: assert property ($changed(h_scl_oe_n)
      |-> $stable(h_sda_oe_n))
      else $error("master moved both lines at once");

endmodule : ifca_link_properties

`default_nettype wire

// File: sim/tb_top.sv
// Purpose: Runs memory and register traffic from the master end.
// Assumes: Shortened bit timing with QTR_CYC of 8.
// Notes:   Mid-byte aborts cannot be commanded through the master.

`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import ifca_pkg::*;

   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [1:0] sel_pins = 2'h0;
   logic cmd_valid = 1'b0;
   ifca_cmd_e cmd = IFCA_CMD_START;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_nack = 1'b0;
   logic cmd_ready;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic rsp_ack;
   logic [14:0] mem_addr;
   logic [4:0] reg_addr;
   int errors = 0;
   int n_checks = 0;

   always #4 clk_sys = ~clk_sys;

   ifca_bus_if bus_if();

   ifca_dev #(.MEM_DEPTH(32768)) ifca_dev_inst (.clk_sys(clk_sys),
      .nrst(nrst), .bus(bus_if), .sel_pins(sel_pins),
      .mem_addr(mem_addr), .reg_addr(reg_addr));

   ifca_host #(.QTR_CYC(8)) ifca_host_inst (.clk_sys(clk_sys),
      .nrst(nrst), .bus(bus_if), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_wdata(cmd_wdata), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));

   ifca_link_properties #(.SEL(2'h0)) ifca_link_properties_inst (
      .clk_sys(clk_sys), .nrst(nrst), .h_scl_o(bus_if.h_scl_o),
      .h_scl_oe_n(bus_if.h_scl_oe_n), .h_sda_o(bus_if.h_sda_o),
      .h_sda_oe_n(bus_if.h_sda_oe_n), .d_sda_o(bus_if.d_sda_o),
      .d_sda_oe_n(bus_if.d_sda_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, what,
                  got, exp);
      end
   endtask : chk

   // The request is held through the taking edge, then the response
   // pulse is awaited under a bound so a stuck master cannot hang here.
   task automatic op(input ifca_cmd_e c, input logic [7:0] d,
                     input logic nk);
      int n;
      n = 0;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd <= c;
      cmd_wdata <= d;
      cmd_nack <= nk;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (rsp_valid !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         errors++;
         $display("wrong value at %0t: no response", $time);
      end
   endtask : op

   task automatic sta();
      op(IFCA_CMD_START, 8'h00, 1'b0);
   endtask : sta

   task automatic sto();
      op(IFCA_CMD_STOP, 8'h00, 1'b0);
   endtask : sto

   task automatic wr(input logic [7:0] d, input logic ack);
      op(IFCA_CMD_WRITE, d, 1'b0);
      chk({15'h0000, rsp_ack}, {15'h0000, ack}, "acknowledge");
   endtask : wr

   task automatic rd(input logic nk, input logic [7:0] exp);
      op(IFCA_CMD_READ, 8'h00, nk);
      chk({8'h00, rsp_data}, {8'h00, exp}, "read data");
   endtask : rd

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      give_verdict();
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk({1'b0, mem_addr}, 16'h0000, "memory latch");
      chk({11'h000, reg_addr}, 16'h0000, "register latch");
      chk({15'h0000, cmd_ready}, 16'h0001, "master ready");
      $display("test reset done");
      // Top address bit is ignored, so FFh FFh lands on the last byte.
      sta();
      wr(8'hA0, 1'b1);
      wr(8'hFF, 1'b1);
      wr(8'hFF, 1'b1);
      wr(8'h11, 1'b1);
      wr(8'h22, 1'b1);
      wr(8'h33, 1'b1);
      wr(8'h44, 1'b1);
      sto();
      chk({1'b0, mem_addr}, 16'h0003, "memory latch");
      $display("test memory write wrap done");
      sta();
      wr(8'hA0, 1'b1);
      wr(8'h7F, 1'b1);
      wr(8'hFF, 1'b1);
      sta();
      wr(8'hA1, 1'b1);
      rd(1'b0, 8'h11);
      rd(1'b1, 8'h22);
      sto();
      chk({1'b0, mem_addr}, 16'h0001, "memory latch");
      $display("test selective read done");
      sta();
      wr(8'hD0, 1'b1);
      wr(8'h18, 1'b1);
      wr(8'h5A, 1'b1);
      wr(8'hA5, 1'b1);
      sto();
      chk({11'h000, reg_addr}, 16'h0001, "register latch");
      chk({1'b0, mem_addr}, 16'h0001, "memory latch");
      sta();
      wr(8'hD0, 1'b1);
      wr(8'h18, 1'b1);
      sta();
      wr(8'hD1, 1'b1);
      rd(1'b0, 8'h5A);
      rd(1'b1, 8'hA5);
      sto();
      $display("test register access done");
      // A memory read after register traffic resumes at the old latch.
      sta();
      wr(8'hA1, 1'b1);
      rd(1'b0, 8'h33);
      rd(1'b1, 8'h44);
      sto();
      $display("test memory resume done");
      // A stop straight after the two address bytes must leave location 1 intact.
      sta();
      wr(8'hA0, 1'b1);
      wr(8'h00, 1'b1);
      wr(8'h01, 1'b1);
      sto();
      sta();
      wr(8'hA1, 1'b1);
      rd(1'b1, 8'h33);
      sto();
      $display("test write abort done");
      sta();
      wr(8'hD0, 1'b1);
      wr(8'h19, 1'b0);
      sto();
      sta();
      wr(8'hA2, 1'b0);
      sto();
      sta();
      wr(8'h50, 1'b0);
      sto();
      chk({1'b0, mem_addr}, 16'h0002, "memory latch");
      $display("test refusals done");
      give_verdict();
   end

endmodule : tb_top

`default_nettype wire
